// ===== logic/tgre_dummy_unused.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ===== logic/tgre_engine.sv
// Operation
// R1: gain switches move only on sample edges
// R2: three modes: table, linear ramp, fixed
// R3: 148-entry 9-bit step table, host written
// R4: table reachable only while bank select set
// R5: entry top bit direction, low byte dwell
// R6: dwell 0x00 shortest, 0xFF longest
// R7: whole 1dB steps, or eight eighth steps
// R8: walk table first pointer to last pointer
// R9: trigger loads initial gain, starts immediately
// R10: stop at last entry or limit, hold
// R11: return 1dB per sample, then idle
// R12: trigger sampled on sample clock rising edge
// R13: software trigger repeats curve until cleared
// R14: software trigger accepted within one sample
// R15: table final gain from pointers and decrements
// R16: linear ramp up at programmed rate
// R17: ramp rate units follow interpolation setting
// R18: ramp ignores table, final from pointer difference
// R19: linear ramp only increases gain
// R20: fixed mode gain is coarse plus fine
// R21: coarse codes above 0x24 act as 0x24; code clamps only bits 5:0, so codes 0x40 and up drop bits 7:6 first
// R22: fine adds eighth dB per code
// R23: hold lasts 33 samples per unit
// R24: initial gain is -5dB plus code
// R25: sample period is two input clocks
// R26: host keeps pointers within 1 to 148
// R27: gain presented as whole and eighth parts
`timescale 1ns/100ps
`default_nettype none

module tgre_engine #(
  parameter int HOLD_UNIT = tgre_pkg::HOLD_UNIT
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       sen_n_i,
  input  wire logic       sclk_i,
  input  wire logic       sdata_i,
  input  wire logic       sync_i,
  output logic      [5:0] gain_coarse_o,
  output logic      [2:0] gain_fine_o,
  output logic            engine_busy_o
);
  import tgre_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_STEP, ST_HOLD, ST_RETURN} tgre_state_e;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] meta_reg;
  logic [3:0] pin_reg;
  logic       sclk_old_reg;

  // Two flops on every pin before use
  always_ff @(posedge clk_i) begin
    meta_reg     <= {sync_i, sdata_i, sclk_i, sen_n_i};
    pin_reg      <= meta_reg;
    sclk_old_reg <= pin_reg[1];
  end

  wire sen_n_s   = pin_reg[0];
  wire sclk_rise = pin_reg[1] & ~sclk_old_reg;
  wire sdata_s   = pin_reg[2];
  wire sync_s    = pin_reg[3];

  // ----------------------------------------------------------------
  // Serial write port
  // ----------------------------------------------------------------
  logic [FRAME_BITS-2:0] shift_reg;
  logic [4:0]            bitcnt_reg;
  logic                  wr_reg;
  logic [FRAME_BITS-1:0] frame_reg;

  // Shift MSB first; the 24th bit commits the word
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || sen_n_s) begin
      bitcnt_reg <= 5'h00;
      wr_reg     <= 1'b0;
    end else begin
      wr_reg <= 1'b0;
      if (sclk_rise) begin
        shift_reg  <= {shift_reg[FRAME_BITS-3:0], sdata_s};
        bitcnt_reg <= bitcnt_reg + 5'h01;
        if (bitcnt_reg == FRAME_LAST) begin
          frame_reg <= {shift_reg, sdata_s};
          wr_reg    <= 1'b1;
        end
      end
    end
  end

  wire [7:0]  wr_addr = frame_reg[ADDR_MSB:ADDR_LSB];
  wire [15:0] wr_data = frame_reg[DATA_MSB:0];

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic       bank_reg;
  logic [7:0] first_reg;
  logic [7:0] last_reg;
  logic [7:0] start_reg;
  logic [7:0] hold_reg;
  logic [7:0] mode_reg;
  logic [7:0] coarse_reg;
  logic [7:0] slope_reg;

  wire in_bank  = wr_reg & bank_reg;
  wire tab_hit  = in_bank & (wr_addr >= ADDR_TAB_LO) & (wr_addr <= ADDR_TAB_HI); // R4
  wire [7:0] tab_wr_idx = wr_addr - ADDR_TAB_LO;

  // Address 0 always reachable; the rest only with bank select
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bank_reg   <= 1'b0;
      first_reg  <= RST_BYTE;
      last_reg   <= RST_BYTE;
      start_reg  <= RST_BYTE;
      hold_reg   <= RST_BYTE;
      mode_reg   <= RST_BYTE;
      coarse_reg <= RST_BYTE;
      slope_reg  <= RST_BYTE;
    end else begin
      if (wr_reg && wr_addr == ADDR_BANK) begin
        bank_reg <= wr_data[BANK_BIT];
      end
      if (in_bank) begin
        case (wr_addr)
          ADDR_FIRST:  first_reg  <= wr_data[7:0];
          ADDR_LAST:   last_reg   <= wr_data[7:0];
          ADDR_START:  start_reg  <= wr_data[7:0];
          ADDR_HOLD:   hold_reg   <= wr_data[7:0];
          ADDR_MODE:   mode_reg   <= wr_data[7:0];
          ADDR_COARSE: coarse_reg <= wr_data[7:0];
          ADDR_SLOPE:  slope_reg  <= wr_data[7:0];
          default: ;
        endcase
      end
    end
  end

  wire interp     = start_reg[INTERP_BIT];
  wire soft_trig  = mode_reg[SOFT_BIT];
  wire uniform    = mode_reg[UNIFORM_BIT];   // R2
  wire fixed_mode = mode_reg[FIXED_BIT];

  // ----------------------------------------------------------------
  // Step table
  // ----------------------------------------------------------------
  logic [7:0] ptr_reg;
  logic [8:0] entry;

  // Pointer is 1-based, storage is 0-based
  wire [7:0] tab_rd_idx = ptr_reg - ADDR_TAB_LO;

  tgre_table_mem #(
    .DEPTH (TABLE_DEPTH),
    .WIDTH (TABLE_WIDTH),
    .AW    (TABLE_AW)
  ) u_table (
    .clk_i     (clk_i),
    .wr_en_i   (tab_hit),                    // R3
    .wr_addr_i (tab_wr_idx),
    .wr_data_i (wr_data[TABLE_WIDTH-1:0]),
    .rd_addr_i (tab_rd_idx),
    .rd_data_o (entry)
  );

  // ----------------------------------------------------------------
  // Sample tick and trigger
  // ----------------------------------------------------------------
  logic phase_reg;
  logic sync_old_reg;

  // Sample period is two input clocks
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      phase_reg    <= 1'b0;
      sync_old_reg <= 1'b0;
    end else begin
      phase_reg <= ~phase_reg;                  // R25
      if (phase_reg) begin
        sync_old_reg <= sync_s;
      end
    end
  end

  wire tick     = phase_reg;
  wire pin_trig = sync_s & ~sync_old_reg;       // R12
  wire trigger  = pin_trig | soft_trig;         // R13 R14

  // ----------------------------------------------------------------
  // Step arithmetic
  // ----------------------------------------------------------------
  // Engine state, declared ahead of the arithmetic that reads it
  tgre_state_e state_reg;
  logic [8:0]  gain_reg;
  logic [2:0]  sub_reg;
  logic [7:0]  dwell_cnt_reg;
  logic [15:0] hold_cnt_reg;

  // Ramp mode never reads the table and only climbs
  wire       dir_down = uniform ? 1'b0 : entry[DIR_BIT];        // R19 R5
  wire [7:0] dwell    = uniform ? slope_reg : entry[7:0];       // R16 R17
  wire [7:0] dwell_ef = (dwell == 8'h00) ? 8'h01 : dwell;       // R6
  wire [8:0] delta    = interp ? STEP_FINE : STEP_WHOLE;        // R7
  wire [8:0] room_up  = GAIN_MAX - gain_reg;
  wire       limit    = dir_down ? (gain_reg < delta) : (room_up < delta); // R10
  wire [8:0] gain_mv  = dir_down ? gain_reg - delta : gain_reg + delta;
  wire       is_last  = (ptr_reg >= last_reg);                   // R8
  wire       sub_end  = (sub_reg == SUB_LAST);
  // Last entry: no whole step, or only seven eighth steps
  wire       do_step  = interp ? ~(is_last & sub_end) : (sub_end & ~is_last); // R15 R18

  wire [5:0] start_cl = (start_reg[5:0] > COARSE_MAX) ? COARSE_MAX : start_reg[5:0];
  wire [8:0] start_g  = {start_cl, 3'h0};                        // R24
  wire [5:0] coarse_cl = (coarse_reg[5:0] > COARSE_MAX) ? COARSE_MAX : coarse_reg[5:0]; // R21
  wire [8:0] fixed_g  = {coarse_cl, mode_reg[2:0]};               // R20 R22
  wire [8:0] ret_up   = start_g - gain_reg;
  wire [8:0] ret_dn   = gain_reg - start_g;
  // One whole dB per sample, landing exactly on start
  wire [8:0] ret_g    = (gain_reg > start_g) ? ((ret_dn > STEP_WHOLE) ? gain_reg - STEP_WHOLE : start_g)
                                             : ((ret_up > STEP_WHOLE) ? gain_reg + STEP_WHOLE : start_g); // R11
  wire [15:0] hold_ld = 16'(int'(hold_reg) * HOLD_UNIT);          // R23

  // ----------------------------------------------------------------
  // Engine
  // ----------------------------------------------------------------
  // Everything moves on the sample tick only
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg     <= ST_IDLE;
      gain_reg      <= RST_GAIN;
      ptr_reg       <= RST_BYTE;
      sub_reg       <= 3'h0;
      dwell_cnt_reg <= 8'h00;
      hold_cnt_reg  <= 16'h0000;
    end else if (tick) begin                    // R1 R27
      if (fixed_mode) begin
        state_reg <= ST_IDLE;
        gain_reg  <= fixed_g;                   // R20
      end else begin
        case (state_reg)
          ST_IDLE: begin
            if (trigger) begin
              gain_reg      <= start_g;         // R9
              ptr_reg       <= first_reg;       // R8
              sub_reg       <= 3'h0;
              dwell_cnt_reg <= 8'h01;
              state_reg     <= ST_STEP;
            end
          end
          ST_STEP: begin
            if (dwell_cnt_reg < dwell_ef) begin
              dwell_cnt_reg <= dwell_cnt_reg + 8'h01;
            end else if (do_step && limit) begin
              hold_cnt_reg <= hold_ld;          // R10
              state_reg    <= ST_HOLD;
            end else begin
              dwell_cnt_reg <= 8'h01;
              if (do_step) begin
                gain_reg <= gain_mv;            // R7
              end
              sub_reg <= sub_reg + 3'h1;
              if (sub_end) begin
                if (is_last) begin
                  hold_cnt_reg <= hold_ld;
                  state_reg    <= ST_HOLD;
                end else begin
                  ptr_reg <= ptr_reg + 8'h01;
                end
              end
            end
          end
          ST_HOLD: begin
            // Expiry takes the first return step itself, so a zero hold adds one sample only
            if (hold_cnt_reg == 16'h0000) begin
              gain_reg  <= ret_g;               // R23
              state_reg <= ST_RETURN;
            end else begin
              hold_cnt_reg <= hold_cnt_reg - 16'h0001;
            end
          end
          ST_RETURN: begin
            if (gain_reg != start_g) begin
              gain_reg <= ret_g;                // R11
            end else begin
              state_reg <= ST_IDLE;
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic busy_reg;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= (state_reg != ST_IDLE);
    end
  end

  assign gain_coarse_o = gain_reg[8:3];
  assign gain_fine_o   = gain_reg[2:0];
  assign engine_busy_o = busy_reg;

endmodule // tgre_engine

`default_nettype wire

// ===== logic/tgre_pkg.sv
package tgre_pkg;

  // ----------------------------------------------------------------
  // Serial frame layout
  // ----------------------------------------------------------------
  localparam int          FRAME_BITS   = 24;
  localparam int          ADDR_MSB     = 23;
  localparam int          ADDR_LSB     = 16;
  localparam int          DATA_MSB     = 15;
  localparam logic [4:0]  FRAME_LAST   = 5'h17;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_BANK    = 8'h00;
  localparam logic [7:0]  ADDR_TAB_LO  = 8'h01;
  localparam logic [7:0]  ADDR_TAB_HI  = 8'h94;
  localparam logic [7:0]  ADDR_FIRST   = 8'h95;
  localparam logic [7:0]  ADDR_LAST    = 8'h96;
  localparam logic [7:0]  ADDR_START   = 8'h97;
  localparam logic [7:0]  ADDR_HOLD    = 8'h98;
  localparam logic [7:0]  ADDR_MODE    = 8'h99;
  localparam logic [7:0]  ADDR_COARSE  = 8'h9A;
  localparam logic [7:0]  ADDR_SLOPE   = 8'h9B;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int          BANK_BIT     = 2;
  localparam int          INTERP_BIT   = 7;
  localparam int          SOFT_BIT     = 5;
  localparam int          UNIFORM_BIT  = 4;
  localparam int          FIXED_BIT    = 3;
  localparam int          DIR_BIT      = 8;

  // ----------------------------------------------------------------
  // Table and gain figures
  // ----------------------------------------------------------------
  localparam int          TABLE_DEPTH  = 148;
  localparam int          TABLE_WIDTH  = 9;
  localparam int          TABLE_AW     = 8;
  localparam logic [5:0]  COARSE_MAX   = 6'h24;
  localparam logic [8:0]  GAIN_MAX     = 9'h127;
  localparam logic [8:0]  STEP_FINE    = 9'h001;
  localparam logic [8:0]  STEP_WHOLE   = 9'h008;
  localparam logic [2:0]  SUB_LAST     = 3'h7;
  localparam int          HOLD_UNIT    = 33;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [8:0]  RST_GAIN     = 9'h000;

endpackage

// ===== logic/tgre_table_mem.sv
`timescale 1ns/100ps
`default_nettype none

module tgre_table_mem #(
  parameter int DEPTH = 148,
  parameter int WIDTH = 9,
  parameter int AW    = 8
) (
  input  wire logic             clk_i,
  input  wire logic             wr_en_i,
  input  wire logic [AW-1:0]    wr_addr_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  input  wire logic [AW-1:0]    rd_addr_i,
  output logic      [WIDTH-1:0] rd_data_o
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  // Write port; out of range indices are dropped
  always_ff @(posedge clk_i) begin
    if (wr_en_i && (int'(wr_addr_i) < DEPTH)) begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
  end

  // Registered read, one clock of latency
  always_ff @(posedge clk_i) begin
    rd_data_o <= mem_q[rd_addr_i];
  end

endmodule // tgre_table_mem

`default_nettype wire

// ===== verification/test_time_gain_ramp_engine.sv
`timescale 1ns/100ps
`default_nettype none

module test_time_gain_ramp_engine;
  import tgre_pkg::*;
  localparam int HU = 1; // Short hold unit keeps runs brief
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  wire sen_n, sclk, sdata, sync;
  logic [5:0] gc;
  logic [2:0] gf;
  logic busy;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  int ev[$], ed[$], gd[$], tab[149];
  logic [8:0] gv[$];

  tgre_engine #(.HOLD_UNIT(HU)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .sen_n_i(sen_n), .sclk_i(sclk),
    .sdata_i(sdata), .sync_i(sync), .gain_coarse_o(gc), .gain_fine_o(gf), .engine_busy_o(busy));
  tgre_host_model u_host (.clk_i(clk_i), .sen_n_o(sen_n), .sclk_o(sclk), .sdata_o(sdata), .sync_o(sync));

  // 25 MHz clock and a hang limit
  initial forever #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      results();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("tests_run=%0d err_total=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Reference curve, one entry per gain run
  // ----------------------------------------
  function automatic void push(int v, int t);
    if (ev.size() > 0 && ev[$] == v) ed[ed.size()-1] += t;
    else begin
      ev.push_back(v);
      ed.push_back(t);
    end
  endfunction

  task automatic model(input int st, f, l, hold, ip, rp, rate);
    int cur, s8, n, dw, up, nx, stop;
    ev.delete();
    ed.delete();
    s8 = (st > 36 ? 36 : st) * 8;
    cur = s8;
    stop = 0;
    n = rp ? (l > f ? l - f : 0) + 1 : l - f + 1;
    for (int e = 0; e < n && !stop; e++) begin
      dw = rp ? rate : tab[f+e] % 256;
      up = rp ? 1 : tab[f+e] < 256;
      for (int s = 0; s < 8 && !stop; s++) begin
        push(cur, dw < 1 ? 1 : dw);
        if (ip ? (s < 7 || e < n - 1) : (s == 7 && e < n - 1)) begin
          nx = cur + (up ? 1 : -1) * (ip ? 1 : 8);
          if (nx < 0 || nx > 295) stop = 1;
          else cur = nx;
        end
      end
    end
    push(cur, hold * HU + 1);
    while (cur != s8) begin
      cur = cur > s8 ? (cur - 8 < s8 ? s8 : cur - 8) : (cur + 8 > s8 ? s8 : cur + 8);
      push(cur, 1);
    end
  endtask

  // Gain runs seen while busy, durations in clocks
  task automatic capture();
    int w;
    gv.delete();
    gd.delete();
    w = 0;
    while (busy !== 1'b1 && w < 5000) begin
      @(posedge clk_i);
      #1 w++;
    end
    while (busy === 1'b1 && w < 20000) begin
      if (gv.size() > 0 && gv[$] === {gc, gf}) gd[gd.size()-1]++;
      else begin
        gv.push_back({gc, gf});
        gd.push_back(1);
      end
      @(posedge clk_i);
      #1 w++;
    end
  endtask

  // Edge runs are cut by trigger and busy timing, so only inner durations count
  task automatic compare_run();
    check(16'(gv.size()), 16'(ev.size()));
    for (int i = 0; i < ev.size() && i < gv.size(); i++) begin
      check(16'(gv[i]), 16'(ev[i]));
      if (i > 0 && i < ev.size() - 1) check(16'(gd[i]), 16'(ed[i] * 2));
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int f, l, st, hd, rt, ip, rp;
    void'($urandom(32'h3176));
    repeat (8) @(negedge clk_i);
    rst_n_i = 1'b1;
    @(negedge clk_i);
    check(16'({gc, gf, busy}), 16'h0000);
    u_host.write_reg(ADDR_MODE, 16'h000F);
    repeat (8) @(negedge clk_i);
    check(16'({gc, gf}), 16'h0000);
    u_host.write_reg(ADDR_BANK, 16'h0004);
    for (int c = 33; c < 40; c++) begin
      u_host.write_reg(ADDR_COARSE, 16'(c));
      u_host.write_reg(ADDR_MODE, 16'(8 + c % 8));
      repeat (8) @(negedge clk_i);
      check(16'({gc, gf}), 16'((c > 36 ? 36 : c) * 8 + c % 8));
    end
    $display("fixed gain test done");
    for (int k = 0; k < 5; k++) begin
      ip = k % 2;
      rp = k == 2 || k == 3;
      f = 1 + $urandom % 140;
      l = f + $urandom % 5;
      st = $urandom % 48;
      hd = $urandom % 3;
      rt = $urandom % 3;
      u_host.write_reg(ADDR_MODE, 16'h0000);
      for (int i = f; i <= l; i++) begin
        tab[i] = ($urandom % 2) * 256 + $urandom % 4;
        u_host.write_reg(8'(i), 16'(tab[i]));
      end
      u_host.write_reg(ADDR_FIRST, 16'(f));
      u_host.write_reg(ADDR_LAST, 16'(l));
      u_host.write_reg(ADDR_START, 16'(ip * 128 + st));
      u_host.write_reg(ADDR_HOLD, 16'(hd));
      u_host.write_reg(ADDR_SLOPE, 16'(rt));
      u_host.write_reg(ADDR_MODE, 16'(rp * 16));
      model(st, f, l, hd, ip, rp, rt);
      if (k < 4) begin
        fork
          u_host.pulse_sync();
          capture();
        join
        compare_run();
      end else begin
        fork
          u_host.write_reg(ADDR_MODE, 16'h0020);
          capture();
        join
        compare_run();
        fork
          u_host.write_reg(ADDR_MODE, 16'h0000);
          capture();
        join
        compare_run();
        repeat (1500) @(negedge clk_i);
        check(16'(busy), 16'h0000);
      end
      $display("curve test %0d done", k);
    end
    results();
  end
endmodule // test_time_gain_ramp_engine

`default_nettype wire

// ===== verification/tgre_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module tgre_host_model (
  input  wire logic clk_i,
  output logic      sen_n_o,
  output logic      sclk_o,
  output logic      sdata_o,
  output logic      sync_o
);
  // Serial clock stands low outside frames
  initial begin
    sen_n_o = 1'b1;
    sclk_o = 1'b0;
    sdata_o = 1'b0;
    sync_o = 1'b0;
  end
  // Frame msb first; each clock level lasts four clocks, slow enough for the pin sync
  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    logic [23:0] f;
    f = {a, d};
    @(negedge clk_i);
    sen_n_o = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdata_o = f[i];
      repeat (4) @(negedge clk_i);
      sclk_o = 1'b1;
      repeat (4) @(negedge clk_i);
      sclk_o = 1'b0;
    end
    repeat (4) @(negedge clk_i);
    sen_n_o = 1'b1;
    sdata_o = ~sdata_o; // Released line shows no stale bit
  endtask
  // Trigger launched off the falling edge, held across a sample
  task automatic pulse_sync();
    @(negedge clk_i);
    sync_o = 1'b1;
    repeat (4) @(negedge clk_i);
    sync_o = 1'b0;
  endtask
endmodule // tgre_host_model

`default_nettype wire

// ===== verification/tgre_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module tgre_monitor #(
  parameter int HOLD_UNIT = 33
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       sen_n_i,
  input  wire logic       sclk_i,
  input  wire logic       sdata_i,
  input  wire logic       sync_i,
  input  wire logic [5:0] gain_coarse_o,
  input  wire logic [2:0] gain_fine_o,
  input  wire logic       engine_busy_o
);
  logic [8:0] g;
  logic [3:0] quiet_reg;
  assign g = {gain_coarse_o, gain_fine_o};
  // Clocks since host activity; idle gain may only move shortly after it
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !sen_n_i || sync_i) quiet_reg <= 4'h0;
    else if (quiet_reg != 4'hF) quiet_reg <= quiet_reg + 4'h1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  reset_clear_a: assert property ($rose(rst_n_i) |-> g == 9'h000 && !engine_busy_o)
    else $error("gain or busy not cleared by reset");
  tick_aligned_a: assert property ($changed(g) |=> $stable(g))
    else $error("gain moved on two clocks in a row");
  coarse_limit_a: assert property (gain_coarse_o <= 6'h24)
    else $error("coarse gain above top code");
  // A limit on the very first step ends a curve after three samples
  busy_min_a: assert property ($rose(engine_busy_o) |-> engine_busy_o [*6])
    else $error("curve shorter than three samples");
  step_size_a: assert property (engine_busy_o && $past(engine_busy_o) && $changed(g)
    |-> ((g > $past(g)) ? g - $past(g) : $past(g) - g) <= 9'h008) else $error("gain step above 1dB");
  idle_stable_a: assert property ($fell(engine_busy_o) |-> $stable(g) [*2])
    else $error("gain moved as the engine went idle");
  busy_gap_a: assert property ($fell(engine_busy_o) |-> !engine_busy_o [*2])
    else $error("restart without an idle sample");
  idle_quiet_a: assert property (!engine_busy_o && !$past(engine_busy_o) && $changed(g) |-> quiet_reg < 4'hA)
    else $error("idle gain moved without a trigger");
endmodule // tgre_monitor

bind tgre_engine tgre_monitor #(.HOLD_UNIT(HOLD_UNIT)) u_mon (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .sen_n_i(sen_n_i), .sclk_i(sclk_i), .sdata_i(sdata_i), .sync_i(sync_i), .gain_coarse_o(gain_coarse_o),
  .gain_fine_o(gain_fine_o), .engine_busy_o(engine_busy_o));

`default_nettype wire
